// ===== dv/tb_msr_top.sv
// self-checking testbench for the modulation setting registers
`timescale 1ns/10ps
module tb_msr_top
   import msr_pkg::*;
();
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, stat;
   logic [3:0]  pstrb, midx, m_idx;
   logic        load_mod_in, am_request, passive_target_mode, err;
   logic        ext_pin, ext_oe_n, reg_am, shaped, ovr, hiz;
   logic [6:0]  code, m_res;
   logic [7:0]  m_aux, m_ptr;
   int          fails, tests_run;

   msr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .load_mod_in(load_mod_in), .am_request(am_request),
      .passive_target_mode(passive_target_mode),
      .external_load_modulation_pin(ext_pin),
      .external_load_modulation_pin_oe_n(ext_oe_n),
      .regulator_am_active(reg_am), .modulation_index_field(midx),
      .shaped_regulator_modulation(shaped), .drv_override(ovr),
      .drv_code(code), .drv_hiz(hiz));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // reference behaviour of the outputs from the stored model registers;
   // st is the status word those outputs should read back as
   task automatic chk_outs(output logic [31:0] st);
      logic       en, pol, drv, ram, pin;
      logic [3:0] c;
      logic [6:0] cd;
      en  = m_aux[MSR_B_EXT_EN];
      pol = m_aux[MSR_B_PIN_POL];
      drv = passive_target_mode & m_aux[MSR_B_DRV_LM];
      ram = m_aux[MSR_B_RESISTIVE_MODULATION_ENABLE] & am_request;
      c   = load_mod_in ? m_ptr[7:4] : m_ptr[3:0];
      pin = en ? (load_mod_in ^ pol) : pol;
      cd  = drv ? {3'h0, c} : (ram ? m_res : 7'h00);
      st  = {21'h0, !m_aux[MSR_B_REG_OFF] & am_request, pin, drv | ram,
             drv & (c == 4'hF), cd};
      chk(32'(ext_pin), 32'(pin));
      chk(32'(ext_oe_n), 32'(!en));
      chk(32'(reg_am), 32'(!m_aux[MSR_B_REG_OFF] & am_request));
      chk(32'(midx), 32'(m_idx));
      chk(32'(shaped), 32'(m_aux[MSR_B_SHAPED]));
      chk(32'(ovr), 32'(drv | ram));
      if (drv) begin
         chk(32'(code), 32'(c));
         chk(32'(hiz), 32'(c == 4'hF));
      end else if (ram) begin
         chk(32'(code), 32'(m_res));
         chk(32'(hiz), 32'h0);
      end else begin
         chk(32'(code), 32'h0);
         chk(32'(hiz), 32'h0);
      end
   endtask

   // a hang ends the run as a failure
   initial begin
      #40000;
      fails++;
      give_verdict();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      load_mod_in = 1'b0;
      am_request = 1'b0;
      passive_target_mode = 1'b0;
      fails = 0;
      tests_run = 0;
      seed = 32'hDF021B2C;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      chk(32'(ext_oe_n), 32'h1);
      chk(32'(reg_am), 32'h0);
      chk(32'(ovr), 32'h0);
      apb(1'b0, 12'h0A0, 32'h0, 4'h0);
      chk(rd, 32'h00000010);
      chk(32'(err), 32'h0);
      apb(1'b0, 12'h0A4, 32'h0, 4'h0);
      chk(rd, 32'h00000070);
      apb(1'b0, 12'h0A8, 32'h0, 4'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      // strobe low must leave the register alone
      apb(1'b1, 12'h0A0, 32'hFF, 4'h0);
      apb(1'b0, 12'h0A0, 32'h0, 4'h0);
      chk(rd, 32'h00000010);
      // the status word is read-only: a write is ignored without an error
      apb(1'b1, 12'h0B4, 32'hFFFFFFFF, 4'hF);
      chk(32'(err), 32'h0);
      apb(1'b0, 12'h0B4, 32'h0, 4'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         m_aux = seed[7:0] & 8'hFC;
         m_ptr = seed[15:8];
         if (i % 4 == 0) begin
            m_ptr[7:4] = 4'hF;
         end
         if (i % 4 == 1) begin
            m_ptr[3:0] = 4'hF;
         end
         m_idx = seed[19:16];
         m_res = seed[26:20];
         apb(1'b1, 12'h0A0, {24'h0, seed[7:0]}, 4'hF);
         apb(1'b1, 12'h0A4, {24'h0, m_ptr}, 4'hF);
         apb(1'b1, 12'h0B0, {17'h0, m_res, 4'h0, m_idx}, 4'hF);
         apb(1'b0, 12'h0A0, 32'h0, 4'h0);
         chk(rd, {24'h0, m_aux});
         apb(1'b0, 12'h0A4, 32'h0, 4'h0);
         chk(rd, {24'h0, m_ptr});
         apb(1'b0, 12'h0B0, 32'h0, 4'h0);
         chk(rd, {17'h0, m_res, 4'h0, m_idx});
         @(posedge pclk);
         load_mod_in <= seed[27];
         am_request <= seed[28];
         passive_target_mode <= seed[29];
         // outputs are registered: one cycle behind their inputs
         repeat (2) @(posedge pclk);
         #1;
         chk_outs(stat);
         apb(1'b0, 12'h0B4, 32'h0, 4'h0);
         chk(rd, stat);
      end
      // reset again in mid-run: registers and outputs return to defaults
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      m_aux = 8'h10;
      m_ptr = 8'h70;
      m_idx = 4'h7;
      m_res = 7'h00;
      repeat (2) @(posedge pclk);
      #1;
      chk_outs(stat);
      apb(1'b0, 12'h0A0, 32'h0, 4'h0);
      chk(rd, {24'h0, m_aux});
      apb(1'b0, 12'h0A4, 32'h0, 4'h0);
      chk(rd, {24'h0, m_ptr});
      apb(1'b0, 12'h0B4, 32'h0, 4'h0);
      chk(rd, stat);
      give_verdict();
   end
endmodule

// ===== include/msr_drv_if.sv
// driver resistance selection signals between top and selector
`timescale 1ns/10ps
interface msr_drv_if;
   logic       pt_mode;
   logic       drv_lm_en;
   logic       resistive_modulation_enable_en;
   logic       am_request;
   logic       load_mod;
   logic [3:0] ptm_code;
   logic [3:0] pt_code;
   logic [6:0] res_code;
   logic       override;
   logic [6:0] code;
   logic       hiz;

   modport top (output pt_mode, drv_lm_en, resistive_modulation_enable_en, am_request,
                output load_mod, ptm_code, pt_code, res_code,
                input  override, code, hiz);
   modport sel (input  pt_mode, drv_lm_en, resistive_modulation_enable_en, am_request,
                input  load_mod, ptm_code, pt_code, res_code,
                output override, code, hiz);
endinterface

// ===== include/msr_pkg.sv
// constants for the four modulation setting registers
package msr_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] MSR_IDX_AUX  = 8'h28;
   localparam logic [7:0] MSR_IDX_PTR  = 8'h29;
   localparam logic [7:0] MSR_IDX_FLD  = 8'h2C;
   localparam logic [7:0] MSR_IDX_STAT = 8'h2D;
   localparam int         MSR_IDX_SHIFT = 2;

   // auxiliary modulation setting fields
   localparam int MSR_B_REG_OFF  = 7;
   localparam int MSR_B_PIN_POL  = 6;
   localparam int MSR_B_EXT_EN   = 5;
   localparam int MSR_B_DRV_LM   = 4;
   localparam int MSR_B_RESISTIVE_MODULATION_ENABLE   = 3;
   localparam int MSR_B_SHAPED   = 2;
   localparam logic [7:0] MSR_AUX_RST   = 8'h10;
   localparam logic [7:0] MSR_AUX_WMASK = 8'hFC;

   // passive target driver resistance fields
   localparam int MSR_PTM_LSB = 4;
   localparam int MSR_PT_LSB  = 0;
   localparam logic [7:0] MSR_PTR_RST = 8'h70;

   // modulation field register: index in 3:0, resistive code in 14:8
   localparam int MSR_IDXF_LSB = 0;
   localparam int MSR_RESF_LSB = 8;
   localparam logic [3:0] MSR_IDXF_RST = 4'h7;
   localparam logic [6:0] MSR_RESF_RST = 7'h00;

   // status register fields
   localparam int MSR_S_HIZ  = 7;
   localparam int MSR_S_OVR  = 8;
   localparam int MSR_S_PIN  = 9;
   localparam int MSR_S_RAM  = 10;

   localparam logic [3:0] MSR_CODE_HIZ = 4'hF;
endpackage

// ===== rtl/msr_drv_sel.sv
// driver resistance code selection for load and resistive modulation
`timescale 1ns/10ps
module msr_drv_sel
   import msr_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   msr_drv_if.sel    d
);
   function automatic logic is_hiz(input logic [3:0] c);
      return c == MSR_CODE_HIZ;
   endfunction

   logic       lm_sel;
   logic       res_sel;
   logic [3:0] lm_code;
   logic       override_reg;
   logic [6:0] code_reg;
   logic       hiz_reg;
   logic       override_next;
   logic [6:0] code_next;
   logic       hiz_next;

   // driver load modulation wins over resistive AM in target mode
   assign lm_sel  = d.pt_mode && d.drv_lm_en;
   assign res_sel = !lm_sel && d.resistive_modulation_enable_en && d.am_request;
   assign lm_code = d.load_mod ? d.ptm_code : d.pt_code;
   assign override_next = lm_sel || res_sel;
   assign code_next = lm_sel ? {3'h0, lm_code} :
                      res_sel ? d.res_code : 7'h00;
   assign hiz_next  = lm_sel && is_hiz(lm_code);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         override_reg <= 1'b0;
         code_reg     <= 7'h00;
         hiz_reg      <= 1'b0;
      end else begin
         override_reg <= override_next;
         code_reg     <= code_next;
         hiz_reg      <= hiz_next;
      end
   end

   assign d.override = override_reg;
   assign d.code     = code_reg;
   assign d.hiz      = hiz_reg;
endmodule

// ===== rtl/msr_top.sv
// modulation setting registers with apb access and modulation outputs
`timescale 1ns/10ps
module msr_top
   import msr_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              load_mod_in,
   input  wire logic              am_request,
   input  wire logic              passive_target_mode,
   output logic                   external_load_modulation_pin,
   output logic                   external_load_modulation_pin_oe_n,
   output logic                   regulator_am_active,
   output logic      [3:0]        modulation_index_field,
   output logic                   shaped_regulator_modulation,
   output logic                   drv_override,
   output logic      [6:0]        drv_code,
   output logic                   drv_hiz
);
   // the word decode needs eight index bits above the byte offset
   if (ADDR_W < 8 + MSR_IDX_SHIFT) begin : g_addr_chk
      $error("ADDR_W too small for the register map");
   end

   // word decode shared by every register
   function automatic logic hit_idx(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction

   msr_drv_if drv ();

   logic [7:0]  aux_reg;
   logic [7:0]  ptr_reg;
   logic [3:0]  idxf_reg;
   logic [6:0]  resf_reg;
   logic [31:0] prdata_reg;
   logic        pin_reg;
   logic        pin_oe_n_reg;
   logic        ram_reg;
   logic        shaped_reg;
   logic [3:0]  index_reg;

   logic        hit_aux;
   logic        hit_ptr;
   logic        hit_fld;
   logic        hit_stat;
   logic        hit_any;
   logic        setup;
   logic        access;
   logic        wr_lane0;
   logic        wr_lane1;
   logic [31:0] rd_word;
   logic [31:0] stat_word;
   logic [7:0]  aux_next;
   logic [7:0]  ptr_next;
   logic [3:0]  idxf_next;
   logic [6:0]  resf_next;
   logic [31:0] prdata_next;
   logic        pin_next;
   logic        pin_oe_n_next;
   logic        ram_next;

   // apb decode
   assign hit_aux  = hit_idx(paddr, MSR_IDX_AUX);
   assign hit_ptr  = hit_idx(paddr, MSR_IDX_PTR);
   assign hit_fld  = hit_idx(paddr, MSR_IDX_FLD);
   assign hit_stat = hit_idx(paddr, MSR_IDX_STAT);
   assign hit_any  = hit_aux || hit_ptr || hit_fld || hit_stat;
   assign setup    = psel && !penable;
   assign access   = psel && penable;
   assign wr_lane0 = access && pwrite && pstrb[0];
   assign wr_lane1 = access && pwrite && pstrb[1];

   // zero wait states; unmapped words answer with an error
   assign pready  = 1'b1;
   assign pslverr = access && !hit_any;

   // reserved bits are masked so they never store a one
   assign aux_next = (wr_lane0 && hit_aux) ?
                     (pwdata[7:0] & MSR_AUX_WMASK) : aux_reg;
   assign ptr_next = (wr_lane0 && hit_ptr) ? pwdata[7:0] : ptr_reg;
   assign idxf_next = (wr_lane0 && hit_fld) ?
                      pwdata[MSR_IDXF_LSB +: 4] : idxf_reg;
   assign resf_next = (wr_lane1 && hit_fld) ?
                      pwdata[MSR_RESF_LSB +: 7] : resf_reg;

   assign stat_word = {21'h0, ram_reg, pin_reg, drv.override,
                       drv.hiz, drv.code};
   assign rd_word = hit_aux  ? {24'h0, aux_reg} :
                    hit_ptr  ? {24'h0, ptr_reg} :
                    hit_fld  ? {17'h0, resf_reg, 4'h0, idxf_reg} :
                    hit_stat ? stat_word : 32'h0;
   // read data is captured in the setup cycle and held through access
   assign prdata_next = (setup && !pwrite) ? rd_word : prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_reg    <= MSR_AUX_RST;
         ptr_reg    <= MSR_PTR_RST;
         idxf_reg   <= MSR_IDXF_RST;
         resf_reg   <= MSR_RESF_RST;
         prdata_reg <= 32'h0;
      end else begin
         aux_reg    <= aux_next;
         ptr_reg    <= ptr_next;
         idxf_reg   <= idxf_next;
         resf_reg   <= resf_next;
         prdata_reg <= prdata_next;
      end
   end
   assign prdata = prdata_reg;

   // external pin: idle at the inactive level and released when off
   assign pin_next = aux_reg[MSR_B_EXT_EN] ?
                     (load_mod_in ^ aux_reg[MSR_B_PIN_POL]) :
                     aux_reg[MSR_B_PIN_POL];
   assign pin_oe_n_next = !aux_reg[MSR_B_EXT_EN];
   // inverted enable: a cleared bit lets the AM index drive the regulator
   assign ram_next = !aux_reg[MSR_B_REG_OFF] && am_request;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg      <= 1'b0;
         pin_oe_n_reg <= 1'b1;
         ram_reg      <= 1'b0;
         shaped_reg   <= 1'b0;
         index_reg    <= MSR_IDXF_RST;
      end else begin
         pin_reg      <= pin_next;
         pin_oe_n_reg <= pin_oe_n_next;
         ram_reg      <= ram_next;
         shaped_reg   <= aux_reg[MSR_B_SHAPED];
         index_reg    <= idxf_reg;
      end
   end

   assign external_load_modulation_pin      = pin_reg;
   assign external_load_modulation_pin_oe_n = pin_oe_n_reg;
   assign regulator_am_active               = ram_reg;
   assign modulation_index_field            = index_reg;
   // the shaped setting is passed on as written; its use is software's
   assign shaped_regulator_modulation       = shaped_reg;

   // driver resistance selection
   // target codes are used as stored: software loads them before mode
   assign drv.pt_mode    = passive_target_mode;
   assign drv.drv_lm_en  = aux_reg[MSR_B_DRV_LM];
   assign drv.resistive_modulation_enable_en  = aux_reg[MSR_B_RESISTIVE_MODULATION_ENABLE];
   assign drv.am_request = am_request;
   assign drv.load_mod   = load_mod_in;
   assign drv.ptm_code   = ptr_reg[MSR_PTM_LSB +: 4];
   assign drv.pt_code    = ptr_reg[MSR_PT_LSB +: 4];
   assign drv.res_code   = resf_reg;

   msr_drv_sel u_sel (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (drv)
   );

   assign drv_override = drv.override;
   assign drv_code     = drv.code;
   assign drv_hiz      = drv.hiz;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_REGAM_ON: assert property (
      !aux_reg[MSR_B_REG_OFF] && am_request |=> regulator_am_active)
      else $error("regulator AM not active while enabled");

   AST_REGAM_OFF: assert property (
      aux_reg[MSR_B_REG_OFF] |=> !regulator_am_active)
      else $error("regulator AM active while disabled");

   AST_PIN_POL: assert property (
      aux_reg[MSR_B_EXT_EN] |=> !external_load_modulation_pin_oe_n &&
      external_load_modulation_pin ==
      ($past(load_mod_in) ^ $past(aux_reg[MSR_B_PIN_POL])))
      else $error("external pin level wrong for its polarity");

   AST_PIN_IDLE: assert property (
      !aux_reg[MSR_B_EXT_EN] |=> external_load_modulation_pin_oe_n &&
      external_load_modulation_pin == $past(aux_reg[MSR_B_PIN_POL]))
      else $error("external pin active while disabled");

   AST_DRV_MOD: assert property (
      passive_target_mode && aux_reg[MSR_B_DRV_LM] && load_mod_in
      |=> drv_override && drv_code == {3'h0, $past(ptr_reg[7:4])})
      else $error("modulated code not applied");

   AST_DRV_UNMOD: assert property (
      passive_target_mode && aux_reg[MSR_B_DRV_LM] && !load_mod_in
      |=> drv_override && drv_code == {3'h0, $past(ptr_reg[3:0])})
      else $error("unmodulated code not applied");

   AST_RESISTIVE_MODULATION_ENABLE: assert property (
      !(passive_target_mode && aux_reg[MSR_B_DRV_LM]) &&
      aux_reg[MSR_B_RESISTIVE_MODULATION_ENABLE] && am_request
      |=> drv_override && !drv_hiz && drv_code == $past(resf_reg))
      else $error("resistive AM code not applied");

   AST_NO_OVR: assert property (
      !(passive_target_mode && aux_reg[MSR_B_DRV_LM]) &&
      !(aux_reg[MSR_B_RESISTIVE_MODULATION_ENABLE] && am_request)
      |=> !drv_override && !drv_hiz)
      else $error("driver override without a cause");

   AST_HIZ: assert property (
      drv_hiz == (drv_override && drv_code == 7'h0F &&
      $past(passive_target_mode && aux_reg[MSR_B_DRV_LM])))
      else $error("high impedance not tied to code 15");

   AST_RSV: assert property (
      aux_reg[1:0] == 2'b00)
      else $error("reserved auxiliary bits set");

   AST_PTR_WR: assert property (
      wr_lane0 && hit_ptr |=> ptr_reg == $past(pwdata[7:0]) ##1
      ptr_reg == $past(ptr_reg) || $past(wr_lane0 && hit_ptr))
      else $error("target register write lost");

   AST_AUX_WR: assert property (
      wr_lane0 && hit_aux
      |=> aux_reg == ($past(pwdata[7:0]) & MSR_AUX_WMASK))
      else $error("auxiliary register write lost");

   AST_AUX_HOLD: assert property (
      !(wr_lane0 && hit_aux) |=> $stable(aux_reg))
      else $error("auxiliary register changed without a write");

   AST_PTR_HOLD: assert property (
      !(wr_lane0 && hit_ptr) |=> $stable(ptr_reg))
      else $error("target register changed without a write");

   AST_FLD_WR: assert property (
      wr_lane1 && hit_fld |=> resf_reg == $past(pwdata[MSR_RESF_LSB +: 7]))
      else $error("resistive field write lost");

   AST_FLD_HOLD: assert property (
      !(wr_lane1 && hit_fld) |=> $stable(resf_reg))
      else $error("resistive field changed without a write");

   AST_IDX_COPY: assert property (
      1'b1 |=> modulation_index_field == $past(idxf_reg))
      else $error("modulation index output not following its field");

   AST_REGAM_IDLE: assert property (
      !am_request |=> !regulator_am_active)
      else $error("regulator AM active without a request");

   AST_PIN_FOLLOW: assert property (
      aux_reg[MSR_B_EXT_EN] && $stable(aux_reg) && $changed(load_mod_in)
      |=> $changed(external_load_modulation_pin))
      else $error("external pin does not follow load modulation");

   AST_OE_FOLLOW: assert property (
      external_load_modulation_pin_oe_n == !$past(aux_reg[MSR_B_EXT_EN]))
      else $error("external pin enable does not follow its bit");

   AST_HIZ_CODE: assert property (
      drv_hiz |-> drv_override && drv_code == {3'h0, MSR_CODE_HIZ})
      else $error("high impedance with a code other than 15");

   AST_LM_PRIO: assert property (
      passive_target_mode && aux_reg[MSR_B_DRV_LM] && aux_reg[MSR_B_RESISTIVE_MODULATION_ENABLE]
      |=> drv_code[6:4] == 3'h0)
      else $error("resistive code used during driver load modulation");

   AST_RD_AUX: assert property (
      setup && !pwrite && hit_aux |=> prdata == {24'h0, $past(aux_reg)})
      else $error("auxiliary register read wrong");

   AST_RD_PTR: assert property (
      setup && !pwrite && hit_ptr |=> prdata == {24'h0, $past(ptr_reg)})
      else $error("target register read wrong");

   COV_EXT_PIN: cover property (
      !external_load_modulation_pin_oe_n ##1
      external_load_modulation_pin != $past(external_load_modulation_pin));
   COV_HIZ: cover property (drv_hiz);
   COV_RESISTIVE_MODULATION_ENABLE: cover property (drv_override && !drv_hiz &&
                               !$past(passive_target_mode));
   COV_REGAM: cover property (regulator_am_active [*3]);
   COV_DRV_LM: cover property (drv_override && !drv_hiz &&
                               $past(passive_target_mode));
endmodule
